// [hw/otmc_pkg.sv]
// Shared constants and types of the transceiver mode-control block
package otmc_pkg;
  // Control register 1 field positions
  localparam int C1_SPEED     = 0;
  localparam int C1_SUSPEND   = 1;
  localparam int C1_LINE_MODE = 2;
  localparam int C1_PASS      = 3;
  localparam int C1_ACON_EN   = 4;
  localparam int C1_UART      = 6;
  // Control register 2 field positions
  localparam int C2_DP_PU     = 0;
  localparam int C2_DM_PU     = 1;
  localparam int C2_DP_PD     = 2;
  localparam int C2_DM_PD     = 3;
  localparam int C2_ID_GND    = 4;
  localparam int C2_VBUS_DRV  = 5;
  // Control register 3 field positions
  localparam int C3_BIAS      = 1;
  localparam int C3_BIDI      = 2;
  localparam int C3_BDIR0     = 3;
  localparam int C3_BDIR1     = 4;
  localparam int C3_LOW_RAIL  = 7;
  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h03;
  localparam logic [7:0] CTRL2_RST = 8'h0C;
  localparam logic [7:0] CTRL3_RST = 8'h14;
  // Receive sample word: {diff, plus, minus, se0}
  localparam int SAMPLE_W = 4;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_USB,
    MODE_UART,
    MODE_PASS,
    MODE_AUDIO
  } otmc_mode_type;
endpackage : otmc_pkg

// [hw/otmc_buf_if.sv]
// Valid/ready carrier between the mode-control top and its sample buffer
`timescale 1ns/1ps
`default_nettype none
interface otmc_buf_if #(parameter int W = 4);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport buf_side (input in_valid, in_data, out_ready,
                    output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface : otmc_buf_if
`default_nettype wire

// [hw/otmc_sample_buf.sv]
// Two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module otmc_sample_buf #(
  parameter int W     = 4,
  parameter int DEPTH = 2
) (
  // Clock and control
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  ce,
  // Buffer ports
  otmc_buf_if.buf_side bi
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]   mem_q [DEPTH];
  logic [AW-1:0]  wr_q;
  logic [AW-1:0]  rd_q;
  logic [AW:0]    cnt_q;
  logic           push;
  logic           pop;

  // Handshakes; full and empty come from the fill count
  assign bi.in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign bi.out_valid = (cnt_q != '0);
  assign bi.out_data  = mem_q[rd_q];
  assign push = ce && bi.in_valid && bi.in_ready;
  assign pop  = ce && bi.out_valid && bi.out_ready;

  // Storage entries
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= bi.in_data;
  end

  // Pointers and fill count
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      if (push && !pop)
        cnt_q <= cnt_q + (AW+1)'(1);
      else if (pop && !push)
        cnt_q <= cnt_q - (AW+1)'(1);
    end
  end
endmodule : otmc_sample_buf
`default_nettype wire

// [hw/otmc_mode_ctrl.sv]
// Mode-control glue of a full-speed OTG transceiver
// What this block does
// - Power-down needs suspend bit and suspend pin
// - Power-down keeps interrupts except auto-connect event
// - Explicit enable bits override suspend power-off
// - Single-ended receiver results always out; OE enables driver
// - Differential receiver output only in split mode
// - Bidi bit off: data pins are inputs
// - Line-mode bit picks encoded or split pins
// - Full speed needs speed bit and pin
// - Decode pass-through and UART select bits
// - Both selects set: keep UART, clear pass
// - Pass-through: D+ data, D- clock, OE low
// - Pass-through enables data-line pull-up automatically
// - Pass-through mirrors host bus; slave ignores commands
// - UART direction bits steer D+ and D-
// - Audio releases drivers, pulls, bus power
// - Audio when selects zero, OE high, ctrl2 zero
// - ID detector reports three states, short event
// - Live bus-valid and session-valid status
// - Low-rail bit selects regulator voltage
// - Driver differential, split UART, or open-drain
// - Behaviour set through set/clear control registers
// - UART select bit 6 beats pass bit 3
// - Bidi bit 2 resets 1; bdir bits 3,4
`timescale 1ns/1ps
`default_nettype none
module otmc_mode_ctrl
  import otmc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic     clk,
  input  wire logic     srst,
  input  wire logic     ce,
  // Control register set and clear strobes
  input  wire logic [7:0] ctrl1_set,
  input  wire logic [7:0] ctrl1_clr,
  input  wire logic [7:0] ctrl2_set,
  input  wire logic [7:0] ctrl2_clr,
  input  wire logic [7:0] ctrl3_set,
  input  wire logic [7:0] ctrl3_clr,
  // Control register read-back
  output logic [7:0]    ctrl1_rd,
  output logic [7:0]    ctrl2_rd,
  output logic [7:0]    ctrl3_rd,
  // Controller-side pins
  input  wire logic     suspend_pin,
  input  wire logic     speed_pin,
  input  wire logic     output_enable_pin_n,
  input  wire logic     plus_line_data_pin_i,
  output logic          plus_line_data_pin_o,
  output logic          plus_line_data_pin_oe_n,
  input  wire logic     minus_line_data_pin_i,
  output logic          minus_line_data_pin_o,
  output logic          minus_line_data_pin_oe_n,
  output logic          diff_receiver_out,
  output logic          diff_receiver_out_oe_n,
  output logic          plus_single_ended_out,
  output logic          minus_single_ended_out,
  input  wire logic     rx_ready,
  output logic          rx_valid,
  output logic          sample_ready,
  // Host two-wire bus for pass-through
  input  wire logic     host_sda_i,
  output logic          host_sda_oe_n,
  input  wire logic     host_scl_i,
  output logic          reg_slave_enable,
  // Cable side line drivers and receivers
  input  wire logic     diff_rx_i,
  input  wire logic     dp_i,
  output logic          dp_o,
  output logic          dp_oe_n,
  input  wire logic     dm_i,
  output logic          dm_o,
  output logic          dm_oe_n,
  output logic          dp_pullup,
  output logic          dm_pullup,
  output logic          dp_pulldown,
  output logic          dm_pulldown,
  output logic          id_ground,
  output logic          vbus_drive,
  // Analog comparators and detectors
  input  wire logic     vbus_valid_cmp,
  input  wire logic     session_valid_cmp,
  input  wire logic     id_gnd_cmp,
  input  wire logic     id_res_cmp,
  input  wire logic     acon_event_in,
  // Mode and status
  output var otmc_mode_type mode,
  output logic          power_down,
  output logic          full_speed,
  output logic          low_rail_select,
  output logic          bias_on,
  output logic          regulator_on,
  output logic          vbus_valid,
  output logic          session_valid,
  output logic          id_floating,
  output logic          id_grounded,
  output logic          id_resistor,
  output logic          id_short_event,
  output logic          acon_event
);
  logic [7:0]    ctrl1_q, ctrl2_q, ctrl3_q;
  logic [7:0]    ctrl1_d;
  logic          susp_q1, susp_q2, speed_q1, speed_q2;
  logic          id_gnd_q;
  logic          pd_d, audio_d;
  otmc_mode_type mode_d;
  logic          line_mode, bidi, oe_n;
  logic          s_diff, s_plus, s_minus, s_se0;
  logic          ppo_d, ppoe_d, mpo_d, mpoe_d, rcvoe_d;
  logic          dpo_d, dpoe_d, dmo_d, dmoe_d, sdaoe_d;
  logic          dppu_d, dmpu_d, dppd_d, dmpd_d, idg_d, vbus_d;

  otmc_buf_if #(.W(SAMPLE_W)) bi ();

  otmc_sample_buf #(.W(SAMPLE_W), .DEPTH(2)) u_buf (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .bi   (bi.buf_side)
  );

  // Receive samples are offered every enabled cycle; a sample is dropped while the buffer is full
  assign bi.in_valid  = 1'b1;
  assign bi.in_data   = {diff_rx_i, dp_i, dm_i, !dp_i && !dm_i};
  assign bi.out_ready = rx_ready;
  assign {s_diff, s_plus, s_minus, s_se0} = bi.out_data;

  assign line_mode = ctrl1_q[C1_LINE_MODE];
  assign bidi      = ctrl3_q[C3_BIDI];
  assign oe_n      = output_enable_pin_n;

  // Set/clear update of control register 1, UART select wins
  always_comb
  begin
    ctrl1_d = (ctrl1_q | ctrl1_set) & ~ctrl1_clr;
    ctrl1_d[7] = 1'b0;
    if (ctrl1_d[C1_UART] && ctrl1_d[C1_PASS])
      ctrl1_d[C1_PASS] = 1'b0;
  end

  // Control registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      ctrl3_q <= CTRL3_RST;
    end
    else if (ce)
    begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= (ctrl2_q | ctrl2_set) & ~ctrl2_clr;
      ctrl3_q <= ((ctrl3_q | ctrl3_set) & ~ctrl3_clr) & 8'hFE;
    end
  end

  // Read-back straight from the control flops
  assign ctrl1_rd = ctrl1_q;
  assign ctrl2_rd = ctrl2_q;
  assign ctrl3_rd = ctrl3_q;

  // Two-flop resynchronisers for the suspend and speed pins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      susp_q1  <= 1'b0;
      susp_q2  <= 1'b0;
      speed_q1 <= 1'b0;
      speed_q2 <= 1'b0;
    end
    else if (ce)
    begin
      susp_q1  <= suspend_pin;
      susp_q2  <= susp_q1;
      speed_q1 <= speed_pin;
      speed_q2 <= speed_q1;
    end
  end

  // Power and operating mode decode
  always_comb
  begin
    pd_d = ctrl1_q[C1_SUSPEND] && susp_q2;
    audio_d = !ctrl1_q[C1_PASS] && !ctrl1_q[C1_UART] && oe_n
              && (ctrl2_q == 8'h00);
    if (audio_d)
      mode_d = MODE_AUDIO;
    else if (ctrl1_q[C1_UART])
      mode_d = MODE_UART;
    else if (ctrl1_q[C1_PASS])
      mode_d = MODE_PASS;
    else
      mode_d = MODE_USB;
  end

  // Pin and line steering per mode
  always_comb
  begin
    ppo_d   = 1'b0;
    ppoe_d  = 1'b1;
    mpo_d   = 1'b0;
    mpoe_d  = 1'b1;
    rcvoe_d = 1'b1;
    dpo_d   = 1'b0;
    dpoe_d  = 1'b1;
    dmo_d   = 1'b0;
    dmoe_d  = 1'b1;
    sdaoe_d = 1'b1;
    dppu_d  = ctrl2_q[C2_DP_PU];
    dmpu_d  = ctrl2_q[C2_DM_PU];
    dppd_d  = ctrl2_q[C2_DP_PD];
    dmpd_d  = ctrl2_q[C2_DM_PD];
    idg_d   = ctrl2_q[C2_ID_GND];
    vbus_d  = ctrl2_q[C2_VBUS_DRV];
    case (mode_d)
      MODE_USB:
      begin
        // Differential driver enabled by the active-low OE pin
        if (!oe_n)
        begin
          dpoe_d = 1'b0;
          dmoe_d = 1'b0;
          if (line_mode)
          begin
            dpo_d = !minus_line_data_pin_i && plus_line_data_pin_i;
            dmo_d = !minus_line_data_pin_i && !plus_line_data_pin_i;
          end
          else
          begin
            dpo_d = plus_line_data_pin_i;
            dmo_d = minus_line_data_pin_i;
          end
        end
        // Receiver results back on the data pins
        if (bidi && oe_n)
        begin
          ppoe_d = 1'b0;
          mpoe_d = 1'b0;
          ppo_d  = line_mode ? s_diff : s_plus;
          mpo_d  = line_mode ? s_se0 : s_minus;
        end
        rcvoe_d = line_mode || !oe_n;
      end
      MODE_UART:
      begin
        // Two single-ended drivers, one direction bit each
        if (!ctrl3_q[C3_BDIR1])
        begin
          dpoe_d = 1'b0;
          dpo_d  = plus_line_data_pin_i;
        end
        else if (bidi)
        begin
          ppoe_d = 1'b0;
          ppo_d  = s_plus;
        end
        if (!ctrl3_q[C3_BDIR0])
        begin
          dmoe_d = 1'b0;
          dmo_d  = minus_line_data_pin_i;
        end
        else if (bidi)
        begin
          mpoe_d = 1'b0;
          mpo_d  = s_minus;
        end
      end
      MODE_PASS:
      begin
        // Open-drain mirror: D+ data, D- clock
        dppu_d = 1'b1;
        if (!oe_n)
        begin
          dpoe_d  = host_sda_i;
          dmoe_d  = host_scl_i;
          sdaoe_d = dp_i || !host_sda_i;
        end
      end
      MODE_AUDIO:
      begin
        // Everything released, no bus power
        dppu_d = 1'b0;
        dmpu_d = 1'b0;
        dppd_d = 1'b0;
        dmpd_d = 1'b0;
        idg_d  = 1'b0;
        vbus_d = 1'b0;
      end
      default:
      begin
        vbus_d = 1'b0;
      end
    endcase
  end

  // Registered steering outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      plus_line_data_pin_o     <= 1'b0;
      plus_line_data_pin_oe_n  <= 1'b1;
      minus_line_data_pin_o    <= 1'b0;
      minus_line_data_pin_oe_n <= 1'b1;
      diff_receiver_out_oe_n   <= 1'b1;
      dp_o          <= 1'b0;
      dp_oe_n       <= 1'b1;
      dm_o          <= 1'b0;
      dm_oe_n       <= 1'b1;
      host_sda_oe_n <= 1'b1;
      dp_pullup     <= 1'b0;
      dm_pullup     <= 1'b0;
      dp_pulldown   <= 1'b0;
      dm_pulldown   <= 1'b0;
      id_ground     <= 1'b0;
      vbus_drive    <= 1'b0;
    end
    else if (ce)
    begin
      plus_line_data_pin_o     <= ppo_d;
      plus_line_data_pin_oe_n  <= ppoe_d;
      minus_line_data_pin_o    <= mpo_d;
      minus_line_data_pin_oe_n <= mpoe_d;
      diff_receiver_out_oe_n   <= rcvoe_d;
      dp_o          <= dpo_d;
      dp_oe_n       <= dpoe_d;
      dm_o          <= dmo_d;
      dm_oe_n       <= dmoe_d;
      host_sda_oe_n <= sdaoe_d;
      dp_pullup     <= dppu_d;
      dm_pullup     <= dmpu_d;
      dp_pulldown   <= dppd_d;
      dm_pulldown   <= dmpd_d;
      id_ground     <= idg_d;
      vbus_drive    <= vbus_d;
    end
  end

  // Mode, power and analog enables
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode             <= MODE_USB;
      power_down       <= 1'b0;
      full_speed       <= 1'b0;
      low_rail_select  <= 1'b0;
      bias_on          <= 1'b1;
      regulator_on     <= 1'b1;
      reg_slave_enable <= 1'b1;
    end
    else if (ce)
    begin
      mode             <= mode_d;
      power_down       <= pd_d;
      full_speed       <= ctrl1_q[C1_SPEED] && speed_q2;
      low_rail_select  <= ctrl3_q[C3_LOW_RAIL];
      bias_on          <= !pd_d || ctrl3_q[C3_BIAS];
      regulator_on     <= !pd_d || |ctrl2_q[C2_DM_PU:C2_DP_PU];
      reg_slave_enable <= (mode_d != MODE_PASS);
    end
  end

  // Live status and events
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      vbus_valid     <= 1'b0;
      session_valid  <= 1'b0;
      id_floating    <= 1'b1;
      id_grounded    <= 1'b0;
      id_resistor    <= 1'b0;
      id_gnd_q       <= 1'b0;
      id_short_event <= 1'b0;
      acon_event     <= 1'b0;
    end
    else if (ce)
    begin
      vbus_valid     <= vbus_valid_cmp;
      session_valid  <= session_valid_cmp;
      id_grounded    <= id_gnd_cmp;
      id_resistor    <= id_res_cmp && !id_gnd_cmp;
      id_floating    <= !id_res_cmp && !id_gnd_cmp;
      id_gnd_q       <= id_gnd_cmp;
      id_short_event <= id_gnd_cmp && !id_gnd_q;
      acon_event     <= acon_event_in && ctrl1_q[C1_ACON_EN] && !pd_d;
    end
  end

  // Buffered receiver results toward the controller
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      diff_receiver_out      <= 1'b0;
      plus_single_ended_out  <= 1'b0;
      minus_single_ended_out <= 1'b0;
      rx_valid               <= 1'b0;
      sample_ready           <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid     <= bi.out_valid;
      sample_ready <= bi.in_ready;
      if (bi.out_valid && rx_ready)
      begin
        diff_receiver_out      <= s_diff;
        plus_single_ended_out  <= s_plus;
        minus_single_ended_out <= s_minus;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_power_down;
    ce |=> power_down == ($past(ctrl1_q[C1_SUSPEND]) && $past(susp_q2));
  endproperty
  a_power_down: assert property (p_power_down)
    else $error("power-down decode wrong");
  property p_full_speed;
    ce |=> full_speed == ($past(ctrl1_q[C1_SPEED]) && $past(speed_q2));
  endproperty
  a_full_speed: assert property (p_full_speed)
    else $error("speed decode wrong");
  property p_uart_wins;
    ctrl1_q[C1_UART] |-> !ctrl1_q[C1_PASS];
  endproperty
  a_uart_wins: assert property (p_uart_wins)
    else $error("pass select kept with UART");
  property p_audio_entry;
    (ce && audio_d) |=> mode == MODE_AUDIO;
  endproperty
  a_audio_entry: assert property (p_audio_entry)
    else $error("audio mode not entered");
  property p_audio_release;
    mode == MODE_AUDIO |-> dp_oe_n && dm_oe_n && !dp_pullup && !vbus_drive
                           && !dp_pulldown && !id_ground;
  endproperty
  a_audio_release: assert property (p_audio_release)
    else $error("audio mode left a driver on");
  property p_bidi_off;
    (ce && !bidi) |=> plus_line_data_pin_oe_n && minus_line_data_pin_oe_n;
  endproperty
  a_bidi_off: assert property (p_bidi_off)
    else $error("data pin driven with bidi off");
  property p_rcv_split;
    $fell(diff_receiver_out_oe_n) |-> !$past(line_mode) && $past(oe_n);
  endproperty
  a_rcv_split: assert property (p_rcv_split)
    else $error("receiver output driven outside split mode");
  property p_pass_pullup;
    mode == MODE_PASS |-> dp_pullup && !reg_slave_enable;
  endproperty
  a_pass_pullup: assert property (p_pass_pullup)
    else $error("pass-through pull-up or slave wrong");
  property p_low_rail;
    ce |=> low_rail_select == $past(ctrl3_q[C3_LOW_RAIL]);
  endproperty
  a_low_rail: assert property (p_low_rail)
    else $error("regulator select wrong");
  property p_acon_pd;
    power_down |-> !acon_event;
  endproperty
  a_acon_pd: assert property (p_acon_pd)
    else $error("auto-connect event in power-down");

  c_audio: cover property (mode == MODE_AUDIO);
  c_pass: cover property (mode == MODE_PASS && !dp_oe_n);
  c_uart: cover property (mode == MODE_UART);
  c_buf_full: cover property (!bi.in_ready);
endmodule : otmc_mode_ctrl
`default_nettype wire

// [test/otmc_ctrl_model.sv]
// Model of the digital OTG controller that faces the data pins
`timescale 1ns/1ps
`default_nettype none
module otmc_ctrl_model (
  // Clock and scenario controls
  input  wire logic clk,
  input  wire logic stall,
  input  wire logic tx,
  input  wire logic tx_plus,
  input  wire logic tx_minus,
  // Block side of the data pins
  input  wire logic plus_line_data_pin_o,
  input  wire logic plus_line_data_pin_oe_n,
  input  wire logic minus_line_data_pin_o,
  input  wire logic minus_line_data_pin_oe_n,
  output logic      output_enable_pin_n,
  output logic      plus_line_data_pin_i,
  output logic      minus_line_data_pin_i,
  output logic      rx_ready
);
  logic plus_last_q = 1'b0;
  logic minus_last_q = 1'b0;
  // Drive the pins only while transmitting; an idle line shows the inverse of its last level
  assign output_enable_pin_n   = !tx;
  assign plus_line_data_pin_i  = !plus_line_data_pin_oe_n ? plus_line_data_pin_o
                                 : (tx ? tx_plus : !plus_last_q);
  assign minus_line_data_pin_i = !minus_line_data_pin_oe_n ? minus_line_data_pin_o
                                 : (tx ? tx_minus : !minus_last_q);
  // Stall stands in for a slow controller
  assign rx_ready = !stall;
  // Remember the last level driven on each line; a released line shows its inverse
  always_ff @(posedge clk)
  begin
    if (tx || !plus_line_data_pin_oe_n)
      plus_last_q  <= plus_line_data_pin_i;
    if (tx || !minus_line_data_pin_oe_n)
      minus_last_q <= minus_line_data_pin_i;
  end
endmodule : otmc_ctrl_model
`default_nettype wire

// [test/otmc_mode_ctrl_tb.sv]
// Self-checking bench of the transceiver mode-control block
`timescale 1ns/1ps
`default_nettype none
module otmc_mode_ctrl_tb
  import otmc_pkg::*;
  ;
  logic clk = 0, srst = 1, stall = 0, tx = 0, tx_plus = 0, tx_minus = 0;
  logic [7:0] sset [3] = '{default: 8'h00};
  logic [7:0] sclr [3] = '{default: 8'h00};
  logic [7:0] ctrl1_rd, ctrl2_rd, ctrl3_rd;
  logic suspend_pin = 0, speed_pin = 0, host_sda_i = 1, host_scl_i = 1;
  logic diff_rx_i = 0, dp_i = 0, dm_i = 0, vbus_valid_cmp = 0, session_valid_cmp = 0;
  logic id_gnd_cmp = 0, output_enable_pin_n, plus_line_data_pin_i, minus_line_data_pin_i;
  logic plus_line_data_pin_o, plus_line_data_pin_oe_n, minus_line_data_pin_o;
  logic minus_line_data_pin_oe_n, diff_receiver_out_oe_n, plus_single_ended_out;
  logic minus_single_ended_out, rx_ready, rx_valid, sample_ready, host_sda_oe_n;
  logic reg_slave_enable, dp_o, dp_oe_n, dm_o, dm_oe_n, dp_pullup, dp_pulldown, dm_pulldown;
  logic vbus_drive, power_down, full_speed, low_rail_select, bias_on, vbus_valid;
  logic session_valid, id_floating, id_grounded, id_short_event;
  logic regulator_on, acon_event, diff_receiver_out, acon_event_in = 1'b1;
  otmc_mode_type mode;
  int bad_count = 0, checks_done = 0, i;
  // Clock
  always #5 clk = ~clk;
  // Block under test and the controller model
  otmc_mode_ctrl i_otmc_mode_ctrl (.clk, .srst, .ce(1'b1), .ctrl1_set(sset[0]),
    .ctrl1_clr(sclr[0]), .ctrl2_set(sset[1]), .ctrl2_clr(sclr[1]), .ctrl3_set(sset[2]),
    .ctrl3_clr(sclr[2]), .ctrl1_rd, .ctrl2_rd, .ctrl3_rd, .suspend_pin, .speed_pin,
    .output_enable_pin_n, .plus_line_data_pin_i, .plus_line_data_pin_o,
    .plus_line_data_pin_oe_n, .minus_line_data_pin_i, .minus_line_data_pin_o,
    .minus_line_data_pin_oe_n, .diff_receiver_out, .diff_receiver_out_oe_n,
    .plus_single_ended_out, .minus_single_ended_out, .rx_ready, .rx_valid, .sample_ready,
    .host_sda_i, .host_sda_oe_n, .host_scl_i, .reg_slave_enable, .diff_rx_i, .dp_i, .dp_o,
    .dp_oe_n, .dm_i, .dm_o, .dm_oe_n, .dp_pullup, .dm_pullup(), .dp_pulldown, .dm_pulldown,
    .id_ground(), .vbus_drive, .vbus_valid_cmp, .session_valid_cmp, .id_gnd_cmp,
    .id_res_cmp(1'b0), .acon_event_in, .mode, .power_down, .full_speed,
    .low_rail_select, .bias_on, .regulator_on, .vbus_valid, .session_valid, .id_floating,
    .id_grounded, .id_resistor(), .id_short_event, .acon_event);
  otmc_ctrl_model i_otmc_ctrl_model (.clk, .stall, .tx, .tx_plus, .tx_minus,
    .plus_line_data_pin_o, .plus_line_data_pin_oe_n, .minus_line_data_pin_o,
    .minus_line_data_pin_oe_n, .output_enable_pin_n, .plus_line_data_pin_i,
    .minus_line_data_pin_i, .rx_ready);
  // Wait n edges, then let outputs settle
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : go
  // One set/clear write to control register r, then settle the outputs
  task automatic wr(input int r, input logic [7:0] s, input logic [7:0] c);
    @(posedge clk);
    sset[r] <= s;
    sclr[r] <= c;
    @(posedge clk);
    sset[r] <= 8'h00;
    sclr[r] <= 8'h00;
    go(2);
  endtask : wr
  // Compare a single bit
  task automatic cb(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: bit got %b want %b", $time, got, exp);
    end
  endtask : cb
  // Compare a byte
  task automatic cv(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: byte got %h want %h", $time, got, exp);
    end
  endtask : cv
  // Compare the operating mode
  task automatic cm(input otmc_mode_type got, input otmc_mode_type exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: mode got %0d want %0d", $time, got, exp);
    end
  endtask : cm
  // Print the counts and the verdict, then end the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    go(1);
    cv(ctrl1_rd, 8'h03);
    cv(ctrl2_rd, 8'h0C);
    cv(ctrl3_rd, 8'h14);
    cm(mode, MODE_USB);
    suspend_pin <= 1'b1;
    speed_pin <= 1'b1;
    go(1);
    cb(full_speed, 1'b0);
    go(3);
    cb(full_speed, 1'b1);
    cb(power_down, 1'b1);
    cb(bias_on, 1'b0);
    cb(regulator_on, 1'b0);
    wr(0, 8'h10, 8'h00);
    cb(acon_event, 1'b0);
    wr(2, 8'h02, 8'h00);
    cb(bias_on, 1'b1);
    wr(0, 8'h00, 8'h03);
    cb(power_down, 1'b0);
    cb(full_speed, 1'b0);
    cb(acon_event, 1'b1);
    wr(0, 8'h48, 8'h10);
    cv(ctrl1_rd, 8'h40);
    cm(mode, MODE_UART);
    wr(0, 8'h08, 8'h40);
    cm(mode, MODE_PASS);
    tx <= 1'b1;
    host_sda_i <= 1'b0;
    go(2);
    cb(dp_oe_n, 1'b0);
    cb(dp_o, 1'b0);
    cb(dm_oe_n, 1'b1);
    cb(host_sda_oe_n, 1'b1);
    cb(dp_pullup, 1'b1);
    cb(reg_slave_enable, 1'b0);
    host_sda_i <= 1'b1;
    host_scl_i <= 1'b0;
    go(2);
    cb(dp_oe_n, 1'b1);
    cb(dm_oe_n, 1'b0);
    cb(host_sda_oe_n, 1'b0);
    wr(0, 8'h04, 8'h08);
    tx_plus <= 1'b1;
    go(2);
    cm(mode, MODE_USB);
    cb(dp_oe_n, 1'b0);
    cb(dp_o, 1'b1);
    cb(dm_o, 1'b0);
    tx_minus <= 1'b1;
    go(2);
    cb(dp_o, 1'b0);
    cb(dm_o, 1'b0);
    tx_plus <= 1'b0;
    wr(0, 8'h00, 8'h04);
    cb(dm_o, 1'b1);
    cb(diff_receiver_out_oe_n, 1'b1);
    tx <= 1'b0;
    dp_i <= 1'b1;
    diff_rx_i <= 1'b1;
    go(5);
    cb(diff_receiver_out_oe_n, 1'b0);
    cb(plus_line_data_pin_oe_n, 1'b0);
    cb(plus_line_data_pin_o, 1'b1);
    cb(plus_single_ended_out, 1'b1);
    cb(minus_single_ended_out, 1'b0);
    cb(diff_receiver_out, 1'b1);
    wr(2, 8'h00, 8'h04);
    cb(plus_line_data_pin_oe_n, 1'b1);
    wr(2, 8'h04, 8'h00);
    wr(0, 8'h40, 8'h00);
    tx <= 1'b1;
    go(2);
    cb(dp_oe_n, 1'b1);
    cb(plus_line_data_pin_oe_n, 1'b0);
    cb(plus_line_data_pin_o, 1'b1);
    cb(dm_oe_n, 1'b0);
    cb(dm_o, 1'b1);
    wr(2, 8'h08, 8'h10);
    cb(dp_oe_n, 1'b0);
    cb(minus_line_data_pin_oe_n, 1'b0);
    cb(minus_line_data_pin_o, 1'b0);
    wr(0, 8'h00, 8'h40);
    wr(1, 8'h20, 8'h00);
    tx <= 1'b0;
    go(2);
    cb(vbus_drive, 1'b1);
    cm(mode, MODE_USB);
    wr(1, 8'h00, 8'hFF);
    cm(mode, MODE_AUDIO);
    cb(dp_oe_n & dm_oe_n, 1'b1);
    cb(plus_line_data_pin_oe_n, 1'b1);
    cb(dp_pulldown | dm_pulldown | vbus_drive, 1'b0);
    wr(2, 8'h80, 8'h00);
    cb(low_rail_select, 1'b1);
    vbus_valid_cmp <= 1'b1;
    session_valid_cmp <= 1'b1;
    id_gnd_cmp <= 1'b1;
    for (i = 0; i < 6 && id_short_event !== 1'b1; i++)
      go(1);
    if (i == 6)
    begin
      bad_count++;
      $display("mismatch at %0t: id short event wait timed out", $time);
      report_and_stop();
    end
    cb(id_short_event, 1'b1);
    go(1);
    cb(id_short_event, 1'b0);
    go(2);
    cb(id_grounded, 1'b1);
    cb(id_floating, 1'b0);
    cb(vbus_valid & session_valid, 1'b1);
    stall <= 1'b1;
    for (i = 0; i < 8 && sample_ready !== 1'b0; i++)
      go(1);
    if (i == 8)
    begin
      bad_count++;
      $display("mismatch at %0t: buffer full wait timed out", $time);
      report_and_stop();
    end
    cb(rx_valid, 1'b1);
    stall <= 1'b0;
    go(4);
    cb(sample_ready, 1'b1);
    report_and_stop();
  end
endmodule : otmc_mode_ctrl_tb
`default_nettype wire
